// >>> src/wcb_pkg.sv
package wcb_pkg;

    // Word addresses of the waveform section
    localparam logic [15:0] OFF_V_SCALE     = 16'h2710;
    localparam logic [15:0] OFF_V_COUNT     = 16'h2711;
    localparam logic [15:0] OFF_V_ERR       = 16'h2712;
    localparam logic [15:0] OFF_V12_FIRST   = 16'h2714;
    localparam logic [15:0] OFF_V12_LAST    = 16'h296b;
    localparam logic [15:0] OFF_V23_FIRST   = 16'h2ee4;
    localparam logic [15:0] OFF_V23_LAST    = 16'h313b;
    localparam logic [15:0] OFF_C_SCALE     = 16'h3e80;
    localparam logic [15:0] OFF_C_COUNT     = 16'h3e81;
    localparam logic [15:0] OFF_C_ERR       = 16'h3e82;
    localparam logic [15:0] OFF_P1_FIRST    = 16'h3e84;
    localparam logic [15:0] OFF_P1_LAST     = 16'h40db;
    localparam logic [15:0] OFF_P3_FIRST    = 16'h4e24;
    localparam logic [15:0] OFF_P3_LAST     = 16'h507b;
    localparam logic [15:0] OFF_I_SCALE     = 16'h55f0;
    localparam logic [15:0] OFF_I_ERR       = 16'h55f1;
    localparam logic [15:0] OFF_I_L12       = 16'h55f2;
    localparam logic [15:0] OFF_I_L23       = 16'h55f4;
    localparam logic [15:0] OFF_I_P1        = 16'h55f8;
    localparam logic [15:0] OFF_I_P3        = 16'h55fc;

    // Indicator words
    localparam logic [15:0] OFF_LED0        = 16'h0c1c;
    localparam logic [15:0] OFF_LED1        = 16'h0c1d;

    // Interrupt registers
    localparam logic [15:0] OFF_IRQ_STATUS  = 16'h5700;
    localparam logic [15:0] OFF_IRQ_CLEAR   = 16'h5701;
    localparam logic [15:0] OFF_IRQ_ENABLE  = 16'h5702;

    // Fixed contents and limits
    localparam logic [15:0] SCALE_EXP       = 16'hfffd;
    localparam logic [8:0]  MAX_SAMPLES     = 9'h12c;
    localparam logic [9:0]  PAGE_SIZE       = 10'h12c;
    localparam logic [9:0]  BANK_DEPTH      = 10'h258;
    localparam logic signed [31:0] SAMPLE_MAX = 32'sh3b9ac9ff;
    localparam logic signed [31:0] SAMPLE_MIN = 32'shc4653601;

    // Reset values
    localparam logic [15:0] WORD_RESET      = 16'h0000;
    localparam logic [31:0] SAMPLE_RESET    = 32'h0000_0000;
    localparam logic [8:0]  COUNT_RESET     = 9'h000;

    // Interrupt event bits
    localparam int          IRQ_W           = 5;
    localparam int          IRQ_CYCLE       = 0;
    localparam int          IRQ_V_ERR       = 1;
    localparam int          IRQ_C_ERR       = 2;
    localparam int          IRQ_I_ERR       = 3;
    localparam int          IRQ_LED         = 4;
    localparam logic [4:0]  IRQ_RESET       = 5'h00;

endpackage

// >>> src/wcb_wave_bank.sv
`timescale 1ns/10ps
`default_nettype none

module wcb_wave_bank
    import wcb_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        smp_valid,
    input  wire logic [31:0] smp_a,
    input  wire logic [31:0] smp_b,
    input  wire logic        cycle_strobe,
    input  wire logic        link_err,
    input  wire logic [8:0]  rd_idx,
    input  wire logic        rd_ch,
    output logic      [31:0] rd_word,
    output logic      [8:0]  count,
    output logic             err
);

    logic [31:0] mem_a [0:599];
    logic [31:0] mem_b [0:599];
    logic        front_reg;
    logic [8:0]  wr_ptr_reg;
    logic [8:0]  count_reg;
    logic        err_reg;

    function automatic logic [31:0] clamp(input logic [31:0] v);
        logic signed [31:0] s;
        s = v;
        if (s > SAMPLE_MAX) begin
            clamp = SAMPLE_MAX;
        end else if (s < SAMPLE_MIN) begin
            clamp = SAMPLE_MIN;
        end else begin
            clamp = v;
        end
    endfunction

    wire         room      = wr_ptr_reg < MAX_SAMPLES;
    wire         take      = smp_valid && room;
    wire  [9:0]  wr_addr   = {1'b0, wr_ptr_reg} + (front_reg ? 10'h000 : PAGE_SIZE);
    wire  [9:0]  rd_addr   = {1'b0, rd_idx} + (front_reg ? PAGE_SIZE : 10'h000);
    wire  [8:0]  count_new = wr_ptr_reg + {8'h00, take};

    // Back page fills from sample one while the front page is read
    always_ff @(posedge ref_clk) begin
        if (take) begin
            mem_a[wr_addr] <= clamp(smp_a);
            mem_b[wr_addr] <= clamp(smp_b);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            front_reg  <= 1'b0;
            wr_ptr_reg <= COUNT_RESET;
            count_reg  <= COUNT_RESET;
            err_reg    <= 1'b0;
        end else if (cycle_strobe) begin
            wr_ptr_reg <= COUNT_RESET;
            err_reg    <= link_err;
            if (!link_err) begin
                front_reg <= ~front_reg;
                count_reg <= count_new;
            end
        end else if (take) begin
            wr_ptr_reg <= wr_ptr_reg + 9'h001;
        end
    end

    assign rd_word = (rd_addr < BANK_DEPTH) ? (rd_ch ? mem_b[rd_addr] : mem_a[rd_addr])
                                            : SAMPLE_RESET;
    assign count   = count_reg;
    assign err     = err_reg;

endmodule // wcb_wave_bank

`default_nettype wire

// >>> src/wcb_waveform_capture.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module wcb_waveform_capture
    import wcb_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        cycle_strobe,
    input  wire logic        v_smp_valid,
    input  wire logic [31:0] v_smp_l12,
    input  wire logic [31:0] v_smp_l23,
    input  wire logic        v_err,
    input  wire logic        c_smp_valid,
    input  wire logic [31:0] c_smp_p1,
    input  wire logic [31:0] c_smp_p3,
    input  wire logic        c_err,
    input  wire logic [31:0] inst_l12,
    input  wire logic [31:0] inst_l23,
    input  wire logic [31:0] inst_p1,
    input  wire logic [31:0] inst_p3,
    input  wire logic        inst_err,
    input  wire logic [15:0] led_state0,
    input  wire logic [15:0] led_state1,
    output logic             irq
);

    // Register state
    logic [15:0]      rdata_reg;
    logic [31:0]      inst_l12_reg;
    logic [31:0]      inst_l23_reg;
    logic [31:0]      inst_p1_reg;
    logic [31:0]      inst_p3_reg;
    logic             inst_err_reg;
    logic [15:0]      led0_reg;
    logic [15:0]      led1_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_status_next;
    logic [IRQ_W-1:0] irq_enable_reg;

    // Bank outputs
    logic [31:0] v_word;
    logic [8:0]  v_count;
    logic        v_err_flag;
    logic [31:0] c_word;
    logic [8:0]  c_count;
    logic        c_err_flag;

    // Clamp for the instantaneous group
    function automatic logic [31:0] clamp(input logic [31:0] v);
        logic signed [31:0] s;
        s = v;
        if (s > SAMPLE_MAX) begin
            clamp = SAMPLE_MAX;
        end else if (s < SAMPLE_MIN) begin
            clamp = SAMPLE_MIN;
        end else begin
            clamp = v;
        end
    endfunction

    // Address decode of the sample arrays
    wire in_v12 = (reg_addr >= OFF_V12_FIRST) && (reg_addr <= OFF_V12_LAST);
    wire in_v23 = (reg_addr >= OFF_V23_FIRST) && (reg_addr <= OFF_V23_LAST);
    wire in_p1  = (reg_addr >= OFF_P1_FIRST) && (reg_addr <= OFF_P1_LAST);
    wire in_p3  = (reg_addr >= OFF_P3_FIRST) && (reg_addr <= OFF_P3_LAST);
    wire in_v   = in_v12 || in_v23;
    wire in_c   = in_p1 || in_p3;

    wire [15:0] v_off = reg_addr - (in_v23 ? OFF_V23_FIRST : OFF_V12_FIRST);
    wire [15:0] c_off = reg_addr - (in_p3 ? OFF_P3_FIRST : OFF_P1_FIRST);
    wire [8:0]  v_idx = v_off[9:1];
    wire [8:0]  c_idx = c_off[9:1];

    // Address decode of the single words
    wire hit_v_scale = reg_addr == OFF_V_SCALE;
    wire hit_v_count = reg_addr == OFF_V_COUNT;
    wire hit_v_err   = reg_addr == OFF_V_ERR;
    wire hit_c_scale = reg_addr == OFF_C_SCALE;
    wire hit_c_count = reg_addr == OFF_C_COUNT;
    wire hit_c_err   = reg_addr == OFF_C_ERR;
    wire hit_i_scale = reg_addr == OFF_I_SCALE;
    wire hit_i_err   = reg_addr == OFF_I_ERR;
    wire hit_i_l12   = reg_addr[15:1] == OFF_I_L12[15:1];
    wire hit_i_l23   = reg_addr[15:1] == OFF_I_L23[15:1];
    wire hit_i_p1    = reg_addr[15:1] == OFF_I_P1[15:1];
    wire hit_i_p3    = reg_addr[15:1] == OFF_I_P3[15:1];
    wire hit_led0    = reg_addr == OFF_LED0;
    wire hit_led1    = reg_addr == OFF_LED1;
    wire hit_status  = reg_addr == OFF_IRQ_STATUS;
    wire hit_clear   = reg_addr == OFF_IRQ_CLEAR;
    wire hit_enable  = reg_addr == OFF_IRQ_ENABLE;

    // Write decode
    wire wr_clear  = reg_wr && hit_clear;
    wire wr_enable = reg_wr && hit_enable;

    // Select of a two-word value
    wire [31:0] dword_sel = in_v      ? v_word :
                            in_c      ? c_word :
                            hit_i_l12 ? inst_l12_reg :
                            hit_i_l23 ? inst_l23_reg :
                            hit_i_p1  ? inst_p1_reg :
                            inst_p3_reg;
    wire        dword_hit = in_v || in_c || hit_i_l12 || hit_i_l23 || hit_i_p1 || hit_i_p3;
    wire [15:0] dword_half = reg_addr[0] ? dword_sel[31:16] : dword_sel[15:0];

    // Select of a single word
    wire [15:0] word_sel =
        (hit_v_scale || hit_c_scale || hit_i_scale) ? SCALE_EXP :
        hit_v_count ? {7'h00, v_count} :
        hit_c_count ? {7'h00, c_count} :
        hit_v_err   ? {15'h0000, v_err_flag} :
        hit_c_err   ? {15'h0000, c_err_flag} :
        hit_i_err   ? {15'h0000, inst_err_reg} :
        hit_led0    ? led0_reg :
        hit_led1    ? led1_reg :
        hit_status  ? {11'h000, irq_status_reg} :
        hit_enable  ? {11'h000, irq_enable_reg} :
        WORD_RESET;

    wire [15:0] rd_mux = dword_hit ? dword_half : word_sel;

    // Events
    wire led_change = (led_state0 != led0_reg) || (led_state1 != led1_reg);
    wire [IRQ_W-1:0] irq_event;

    assign irq_event[IRQ_CYCLE] = cycle_strobe;
    assign irq_event[IRQ_V_ERR] = cycle_strobe && v_err;
    assign irq_event[IRQ_C_ERR] = cycle_strobe && c_err;
    assign irq_event[IRQ_I_ERR] = cycle_strobe && inst_err;
    assign irq_event[IRQ_LED]   = led_change;

    // Voltage section storage
    wcb_wave_bank u_volt_bank (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .smp_valid    (v_smp_valid),
        .smp_a        (v_smp_l12),
        .smp_b        (v_smp_l23),
        .cycle_strobe (cycle_strobe),
        .link_err     (v_err),
        .rd_idx       (v_idx),
        .rd_ch        (in_v23),
        .rd_word      (v_word),
        .count        (v_count),
        .err          (v_err_flag)
    );

    // Current section storage
    wcb_wave_bank u_curr_bank (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .smp_valid    (c_smp_valid),
        .smp_a        (c_smp_p1),
        .smp_b        (c_smp_p3),
        .cycle_strobe (cycle_strobe),
        .link_err     (c_err),
        .rd_idx       (c_idx),
        .rd_ch        (in_p3),
        .rd_word      (c_word),
        .count        (c_count),
        .err          (c_err_flag)
    );

    // Read data stand for one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= WORD_RESET;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : WORD_RESET;
        end
    end

    // Instantaneous group
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inst_err_reg <= 1'b0;
        end else if (cycle_strobe) begin
            inst_err_reg <= inst_err;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inst_l12_reg <= SAMPLE_RESET;
            inst_l23_reg <= SAMPLE_RESET;
            inst_p1_reg  <= SAMPLE_RESET;
            inst_p3_reg  <= SAMPLE_RESET;
        end else if (cycle_strobe && !inst_err) begin
            inst_l12_reg <= clamp(inst_l12);
            inst_l23_reg <= clamp(inst_l23);
            inst_p1_reg  <= clamp(inst_p1);
            inst_p3_reg  <= clamp(inst_p3);
        end
    end

    // Indicator words
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            led0_reg <= WORD_RESET;
            led1_reg <= WORD_RESET;
        end else if (led_change) begin
            led0_reg <= led_state0;
            led1_reg <= led_state1;
        end
    end

    // Sticky status, a new event wins over a clear
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi = gi + 1) begin : g_irq
            assign irq_status_next[gi] = irq_event[gi] ||
                                         (irq_status_reg[gi] && !(wr_clear && reg_wdata[gi]));
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_status_reg <= IRQ_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_enable_reg <= IRQ_RESET;
        end else if (wr_enable) begin
            irq_enable_reg <= reg_wdata[IRQ_W-1:0];
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = |(irq_status_reg & irq_enable_reg);

endmodule // wcb_waveform_capture

`default_nettype wire

// >>> sim/wcb_checker.sv
`timescale 1ns/10ps
`default_nettype none
module wcb_checker
    import wcb_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        cycle_strobe,
    input wire logic        v_smp_valid,
    input wire logic        v_err,
    input wire logic        c_err,
    input wire logic        inst_err,
    input wire logic [15:0] led_state0,
    input wire logic        irq
);
    logic [8:0] acc_reg;
    logic [8:0] cnt_reg;
    logic [2:0] err_reg;
    wire  [8:0] acc_next = (v_smp_valid && acc_reg < MAX_SAMPLES) ? acc_reg + 9'h001 : acc_reg;

    // Expected voltage count, kept on voltage error commits, and last flags
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_reg <= 9'h000;
            cnt_reg <= 9'h000;
            err_reg <= 3'h0;
        end else if (cycle_strobe) begin
            acc_reg <= 9'h000;
            err_reg <= {inst_err, c_err, v_err};
            if (!v_err) begin
                cnt_reg <= acc_next;
            end
        end else begin
            acc_reg <= acc_next;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    property p_scale;
        reg_rd && (reg_addr == OFF_V_SCALE || reg_addr == OFF_C_SCALE
            || reg_addr == OFF_I_SCALE) |=> reg_rdata == SCALE_EXP;
    endproperty
    a_scale: assert property (p_scale) else $error("scale word wrong");
    property p_v_flag;
        reg_rd && reg_addr == OFF_V_ERR |=> reg_rdata == {15'h0000, $past(err_reg[0])};
    endproperty
    a_v_flag: assert property (p_v_flag) else $error("voltage flag wrong");
    property p_c_flag;
        reg_rd && reg_addr == OFF_C_ERR |=> reg_rdata == {15'h0000, $past(err_reg[1])};
    endproperty
    a_c_flag: assert property (p_c_flag) else $error("current flag wrong");
    property p_i_flag;
        reg_rd && reg_addr == OFF_I_ERR |=> reg_rdata == {15'h0000, $past(err_reg[2])};
    endproperty
    a_i_flag: assert property (p_i_flag) else $error("instant flag wrong");
    property p_v_count;
        reg_rd && reg_addr == OFF_V_COUNT |=> reg_rdata == {7'h00, $past(cnt_reg)};
    endproperty
    a_v_count: assert property (p_v_count) else $error("voltage count wrong");
    property p_led;
        reg_rd && reg_addr == OFF_LED0 && $stable(led_state0) && !$past(rst)
            |=> reg_rdata == $past(led_state0);
    endproperty
    a_led: assert property (p_led) else $error("indicator word stale");
    property p_unmapped;
        reg_rd && reg_addr == 16'h1234 |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    c_err_commit: cover property (cycle_strobe && v_err);
    c_irq: cover property ($rose(irq));
    c_full: cover property (cycle_strobe && acc_reg == MAX_SAMPLES);
endmodule // wcb_checker

bind wcb_waveform_capture wcb_checker wcb_checker_i (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_strobe(cycle_strobe),
    .v_smp_valid(v_smp_valid), .v_err(v_err), .c_err(c_err), .inst_err(inst_err),
    .led_state0(led_state0), .irq(irq));
`default_nettype wire

// >>> sim/wcb_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module wcb_cpu_model (
    input  wire logic        ref_clk,
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
endmodule // wcb_cpu_model
`default_nettype wire

// >>> sim/wcb_waveform_capture_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module wcb_waveform_capture_tb_top import wcb_pkg::*;;
    logic        ref_clk, rst, cycle_strobe, v_smp_valid, v_err, c_smp_valid, c_err, inst_err;
    logic [31:0] v_smp_l12, v_smp_l23, c_smp_p1, c_smp_p3, inst_l12, inst_l23, inst_p1, inst_p3;
    logic [15:0] led_state0, led_state1, reg_rdata;
    wire  [15:0] reg_addr, reg_wdata;
    wire         reg_wr, reg_rd;
    logic        irq;
    int          mismatches, n_compared;
    logic [31:0] rows [26] = '{32'h2710fffd, 32'h3e80fffd, 32'h55f0fffd, 32'h27110003,
        32'h27120000, 32'h3e810002, 32'h3e820000, 32'h27140001, 32'h27150005, 32'h27163601,
        32'h2717c465, 32'h27180003, 32'h27190005, 32'h2ee40001, 32'h2ee50006, 32'h3e840001,
        32'h3e850007, 32'h4e26c9ff, 32'h4e273b9a, 32'h55f22222, 32'h55f31111, 32'h55f53333,
        32'h55f8c9ff, 32'h55fd3b9a, 32'h55f10000, 32'h12340000};

    wcb_waveform_capture wcb_waveform_capture_i (.ref_clk(ref_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cycle_strobe(cycle_strobe), .v_smp_valid(v_smp_valid),
        .v_smp_l12(v_smp_l12), .v_smp_l23(v_smp_l23), .v_err(v_err), .c_smp_valid(c_smp_valid),
        .c_smp_p1(c_smp_p1), .c_smp_p3(c_smp_p3), .c_err(c_err), .inst_l12(inst_l12),
        .inst_l23(inst_l23), .inst_p1(inst_p1), .inst_p3(inst_p3), .inst_err(inst_err),
        .led_state0(led_state0), .led_state1(led_state1), .irq(irq));
    wcb_cpu_model wcb_cpu_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    always #5 ref_clk = ~ref_clk;

    task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] a);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t at %h got %h want %h", $time, a, got, exp);
        end
    endtask

    task automatic chk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        wcb_cpu_model_i.rd(a, d);
        chkv(d, exp, a);
    endtask

    // Sample k of the voltage section, and of the current section for k up to nc; k 2 of the first batch is out of range
    task automatic samp(input int n, input int nc, input logic [15:0] hi);
        for (int k = 1; k <= n; k++) begin
            @(posedge ref_clk);
            v_smp_valid <= 1'b1;
            c_smp_valid <= (k <= nc);
            v_smp_l12 <= (k == 2 && hi == 16'h0005) ? 32'hc000_0000 : {hi, k[15:0]};
            v_smp_l23 <= {hi + 16'h0001, k[15:0]};
            c_smp_p1 <= {hi + 16'h0002, k[15:0]};
            c_smp_p3 <= (k == 2 && hi == 16'h0005) ? 32'h3c00_0000 : {hi + 16'h0003, k[15:0]};
        end
        @(posedge ref_clk);
        v_smp_valid <= 1'b0;
        c_smp_valid <= 1'b0;
    endtask

    task automatic strobe(input logic ve, input logic ce, input logic ie);
        @(posedge ref_clk);
        cycle_strobe <= 1'b1;
        {v_err, c_err, inst_err} <= {ve, ce, ie};
        @(posedge ref_clk);
        cycle_strobe <= 1'b0;
        {v_err, c_err, inst_err} <= 3'h0;
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        {ref_clk, cycle_strobe, v_smp_valid, v_err, c_smp_valid, c_err, inst_err} = 7'h00;
        {v_smp_l12, v_smp_l23, c_smp_p1, c_smp_p3} = 128'h0;
        {inst_l12, inst_l23, inst_p1, inst_p3} = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
        {led_state0, led_state1} = 32'h0000_0000;
        rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        chk(OFF_V_COUNT, 16'h0000);
        chk(OFF_I_L12, 16'h0000);
        chkv({15'h0000, irq}, 16'h0000, OFF_IRQ_STATUS);
        $display("reset test done");
        samp(3, 2, 16'h0005);
        strobe(1'b0, 1'b0, 1'b0);
        foreach (rows[i]) chk(rows[i][31:16], rows[i][15:0]);
        $display("table test done");
        inst_l12 <= 32'h0999_aaaa;
        samp(5, 4, 16'h000a);
        strobe(1'b1, 1'b1, 1'b1);
        chk(OFF_V_ERR, 16'h0001);
        chk(OFF_C_ERR, 16'h0001);
        chk(OFF_I_ERR, 16'h0001);
        chk(OFF_V_COUNT, 16'h0003);
        chk(OFF_C_COUNT, 16'h0002);
        chk(OFF_V12_FIRST, 16'h0001);
        chk(OFF_P1_FIRST, 16'h0001);
        chk(OFF_I_L12, 16'h2222);
        $display("error commit test done");
        samp(302, 0, 16'h0009);
        strobe(1'b0, 1'b0, 1'b0);
        chk(OFF_V_COUNT, 16'h012c);
        chk(16'h296a, 16'h012c);
        chk(OFF_V12_LAST, 16'h0009);
        chk(OFF_I_L12, 16'haaaa);
        $display("full period test done");
        samp(2, 2, 16'h000b);
        strobe(1'b0, 1'b1, 1'b0);
        chk(OFF_V_COUNT, 16'h0002);
        chk(16'h2715, 16'h000b);
        chk(OFF_C_COUNT, 16'h0000);
        chk(OFF_C_ERR, 16'h0001);
        chk(OFF_V_ERR, 16'h0000);
        $display("section error test done");
        wcb_cpu_model_i.wr(OFF_IRQ_ENABLE, 16'h0002);
        #1 chkv({15'h0000, irq}, 16'h0001, OFF_IRQ_ENABLE);
        wcb_cpu_model_i.wr(OFF_IRQ_CLEAR, 16'h0002);
        #1 chkv({15'h0000, irq}, 16'h0000, OFF_IRQ_CLEAR);
        chk(OFF_IRQ_STATUS, 16'h000d);
        wcb_cpu_model_i.wr(OFF_V_SCALE, 16'h1234);
        chk(OFF_V_SCALE, SCALE_EXP);
        @(posedge ref_clk);
        led_state0 <= 16'h00a5;
        led_state1 <= 16'h005a;
        repeat (2) @(posedge ref_clk);
        chk(OFF_LED0, 16'h00a5);
        chk(OFF_LED1, 16'h005a);
        chk(OFF_IRQ_STATUS, 16'h001d);
        $display("interrupt and indicator test done");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        chk(OFF_V_COUNT, 16'h0000);
        chk(OFF_IRQ_STATUS, 16'h0010);
        chkv({15'h0000, irq}, 16'h0000, OFF_IRQ_ENABLE);
        $display("mid-run reset test done");
        summarize();
    end

    initial begin
        #100000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
endmodule // wcb_waveform_capture_tb_top
`default_nettype wire
